/* File: design/wdtc_top.sv */
// Watchdog control register, timed unlock and watchdog counter
`timescale 1ns/1ps
module wdtc_top (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire wdtc_pkg::wdtc_bus_type bus,
  output logic [7:0]                  rdata,
  input  wire logic                   safety_level_fuse,
  input  wire logic                   counter_restart_instr,
  input  wire logic                   wdog_osc,
  output logic                        wdog_reset
);
  import wdtc_pkg::*;

  logic                  on_q;
  logic [SEL_W-1:0]      sel_q;
  logic [2:0]            unlock_cnt_q;
  wdtc_win_type          win_q;
  logic                  level2;
  logic                  wr_ctrl;
  logic                  unlock_open;
  logic                  wr_unlock;
  logic                  eff_on;
  logic [1:0]            osc_sync_q;
  logic                  osc_prev_q;
  logic                  osc_tick;
  logic [WDOG_CNT_W-1:0] cnt_q;
  logic                  expire;

  // ****************************************************************
  // Register access decode
  // ****************************************************************
  assign level2      = safety_level_fuse;
  assign wr_ctrl     = bus.wr && (bus.addr == CTRL_ADDR);
  assign unlock_open = (win_q == WDTC_OPEN);
  assign wr_unlock   = wr_ctrl && bus.wdata[BIT_UNLOCK] && bus.wdata[BIT_ON];
  assign eff_on      = on_q || level2;

  // ****************************************************************
  // Control register state
  // ****************************************************************
  // Unlock window: opened by combined write, closes four cycles later
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      win_q        <= WDTC_CLOSED;
      unlock_cnt_q <= UNLOCK_IDLE;
    end else if (wr_unlock) begin
      win_q        <= WDTC_OPEN;
      unlock_cnt_q <= UNLOCK_LOAD;
    end else if (unlock_open) begin
      unlock_cnt_q <= unlock_cnt_q - 3'h1;
      if (unlock_cnt_q == 3'h1 || wr_ctrl) begin
        win_q <= WDTC_CLOSED;  // Window used or expired
      end
    end
  end

  // Enable bit: set freely, cleared only inside the window at level 1
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      on_q <= CTRL_RESET[BIT_ON];
    end else if (wr_ctrl) begin
      if (bus.wdata[BIT_ON]) begin
        on_q <= 1'b1;
      end else if (unlock_open && !level2) begin
        on_q <= 1'b0;
      end
    end
  end

  // Timeout select: changed only inside the window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_q <= CTRL_RESET[SEL_HI:0];
    end else if (wr_ctrl && unlock_open && !bus.wdata[BIT_UNLOCK]) begin
      sel_q <= bus.wdata[SEL_HI:0];
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Read data, one cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= RD_ZERO;
    end else if (bus.rd && bus.addr == CTRL_ADDR) begin
      rdata <= {3'h0, unlock_open, eff_on, sel_q};
    end else begin
      rdata <= RD_ZERO;
    end
  end

  // ****************************************************************
  // Watchdog counter on oscillator ticks
  // ****************************************************************
  // Oscillator is synchronised, then edge-detected on the second stage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_sync_q <= SYNC_ZERO;
      osc_prev_q <= 1'b0;
    end else begin
      osc_sync_q <= {osc_sync_q[0], wdog_osc};
      osc_prev_q <= osc_sync_q[1];
    end
  end
  assign osc_tick = osc_sync_q[1] && !osc_prev_q;
  assign expire   = eff_on && osc_tick
                    && (cnt_q >= wdtc_limit(sel_q) - 22'h1);

  // Counter restarts on instruction, disable and expiry
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (!eff_on || counter_restart_instr || expire) begin
      cnt_q <= '0;
    end else if (osc_tick) begin
      cnt_q <= cnt_q + 22'h1;
    end
  end

  // ****************************************************************
  // Chip reset request
  // ****************************************************************
  // One-cycle chip reset pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdog_reset <= 1'b0;
    end else begin
      wdog_reset <= expire;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Chip reset request never stands for two cycles
  a_pulse_one: assert property (@(posedge clk) disable iff (!nrst)
    wdog_reset |=> !wdog_reset)
    else $error("reset pulse longer than one cycle");
  // A lapse of the period raises the reset request on the next edge
  a_expire_pulse: assert property (@(posedge clk) disable iff (!nrst)
    expire |=> wdog_reset)
    else $error("time-out without reset pulse");
  // A pulse only follows a tick that landed while enabled
  a_pulse_cause: assert property (@(posedge clk) disable iff (!nrst)
    wdog_reset |-> ($past(osc_tick) && $past(eff_on)))
    else $error("reset pulse without an enabled tick");

  // A clear outside the window leaves the enable set
  a_clear_locked: assert property (@(posedge clk) disable iff (!nrst)
    (wr_ctrl && !bus.wdata[BIT_ON] && !unlock_open && on_q) |=> on_q)
    else $error("enable cleared without unlock");
  // A protected clear at level 1 turns the watchdog off
  a_clear_open: assert property (@(posedge clk) disable iff (!nrst)
    (wr_ctrl && unlock_open && !level2 && !bus.wdata[BIT_ON]) |=> !eff_on)
    else $error("protected clear did not disable");
  // Enable bit reads one at level 2
  a_level2_on: assert property (@(posedge clk) disable iff (!nrst)
    (bus.rd && bus.addr == CTRL_ADDR && level2) |=> rdata[BIT_ON])
    else $error("enable reads zero at level 2");
  // At level 2 the counter keeps counting ticks whatever was written
  a_never_off: assert property (@(posedge clk) disable iff (!nrst)
    (level2 && osc_tick && !counter_restart_instr && !expire) |=> cnt_q == $past(cnt_q) + 22'h1)
    else $error("watchdog off at level 2");

  // Window stays open through the fourth edge after the unlock write
  a_window_held: assert property (@(posedge clk) disable iff (!nrst)
    wr_unlock ##1 (!wr_ctrl)[*4] |-> unlock_open)
    else $error("window closed early");
  // Window is shut on the fifth edge
  a_window_len: assert property (@(posedge clk) disable iff (!nrst)
    wr_unlock ##1 (!wr_ctrl)[*4] |=> !unlock_open)
    else $error("window not closed");
  // Combined write opens the window
  a_window_open: assert property (@(posedge clk) disable iff (!nrst)
    wr_unlock |=> unlock_open)
    else $error("window not opened");
  // Combined write also leaves the enable set
  a_unlock_on: assert property (@(posedge clk) disable iff (!nrst)
    wr_unlock |=> on_q)
    else $error("unlock write did not set enable");

  // Writing the enable bit one always enables
  a_enable_set: assert property (@(posedge clk) disable iff (!nrst)
    (wr_ctrl && bus.wdata[BIT_ON]) |=> on_q)
    else $error("enable not set");
  // Restart instruction and disable clear the counter
  a_restart_cnt: assert property (@(posedge clk) disable iff (!nrst)
    (counter_restart_instr || !eff_on) |=> cnt_q == '0)
    else $error("counter not restarted");
  // Select holds while the window is shut
  a_sel_locked: assert property (@(posedge clk) disable iff (!nrst)
    (!unlock_open) |=> $stable(sel_q))
    else $error("select changed while locked");
  // A protected write lands the new select
  a_sel_write: assert property (@(posedge clk) disable iff (!nrst)
    (wr_ctrl && unlock_open && !bus.wdata[BIT_UNLOCK]) |=> sel_q == $past(bus.wdata[SEL_HI:0]))
    else $error("protected select write lost");

  // ****************************************************************
  // Coverage of the main scenarios
  // ****************************************************************
  c_expire: cover property (@(posedge clk) disable iff (!nrst) wdog_reset);
  c_disable: cover property (@(posedge clk) disable iff (!nrst) $fell(on_q));
  c_retime: cover property (@(posedge clk) disable iff (!nrst) !$stable(sel_q));
  c_lapse: cover property (@(posedge clk) disable iff (!nrst)
    $fell(unlock_open) && !$past(wr_ctrl));
  c_level2_expire: cover property (@(posedge clk) disable iff (!nrst) level2 && wdog_reset);
endmodule

/* File: inc/wdtc_pkg.sv */
// Package with constants and types for the watchdog control block
package wdtc_pkg;
  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  CTRL_ADDR     = 8'h00;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam int          BIT_UNLOCK    = 4;
  localparam int          BIT_ON        = 3;
  localparam int          SEL_HI        = 2;
  localparam int          SEL_W         = 3;
  localparam logic [7:0]  RD_ZERO       = 8'h00;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          UNLOCK_CYCLES = 4;
  localparam logic [2:0]  UNLOCK_LOAD   = 3'h4;
  localparam logic [2:0]  UNLOCK_IDLE   = 3'h0;
  localparam int          WDOG_CNT_W    = 22;
  localparam int          KCYC          = 1024;
  localparam logic [1:0]  SYNC_ZERO     = 2'h0;

  // Watchdog oscillator cycles per timeout code, scaled from units of 1K by KCYC
  function automatic logic [WDOG_CNT_W-1:0] wdtc_limit(input logic [SEL_W-1:0] sel);
    logic [WDOG_CNT_W-1:0] k;
    k = WDOG_CNT_W'(16) << sel;   // 16K doubling per code step
    return WDOG_CNT_W'(k * WDOG_CNT_W'(KCYC));
  endfunction

  // Bus request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } wdtc_bus_type;

  // Protected-write window state
  typedef enum logic [1:0] {
    WDTC_CLOSED = 2'b01,
    WDTC_OPEN   = 2'b10
  } wdtc_win_type;
endpackage

/* File: tb/wdtc_top_tb_top.sv */
// Self-checking testbench for the watchdog control block
`timescale 1ns/1ps
module wdtc_top_tb_top;
  import wdtc_pkg::*;
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  logic         fuse = 1'b0;
  logic         restart = 1'b0;
  logic         osc = 1'b0;
  logic         rd_q = 1'b0;
  logic         wdog_reset;
  logic [7:0]   rdata;
  logic [7:0]   expq[$];
  wdtc_bus_type bus = '0;
  int           err_count = 0;
  int           check_count = 0;
  int           tick_n = 0;
  int           hit = 0;
  int           pulses = 0;

  // ****************************************************************
  // Clock, design and result watchers
  // ****************************************************************
  always #20 clk = ~clk;

  wdtc_top wdtc_top_inst (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata),
    .safety_level_fuse(fuse), .counter_restart_instr(restart), .wdog_osc(osc),
    .wdog_reset(wdog_reset));

  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) rd_q <= bus.rd;
  always @(negedge clk) if (rd_q) chk("rdata", rdata, expq.pop_front());

  // Counts reset pulse cycles and notes the tick count at the pulse
  always @(posedge clk) if (wdog_reset === 1'b1) begin
    pulses++;
    hit = tick_n;
  end

  // ****************************************************************
  // Bus and oscillator tasks
  // ****************************************************************
  task op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{w, r, a, d};
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp);
    expq.push_back(exp);
    op(1'b0, 1'b1, a, 8'h00);
  endtask

  task wr(input logic [7:0] d);
    op(1'b1, 1'b0, CTRL_ADDR, d);
  endtask

  task tick(input int n);
    repeat (n) begin
      @(posedge clk);
      osc <= 1'b1;
      tick_n++;
      @(posedge clk);
      osc <= 1'b0;
    end
  endtask

  task wrap_up;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Test run is about 70K cycles; cut off at 90K cycles
  initial begin
    #3600000;
    err_count++;
    wrap_up();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [7:0] v;
    v = $urandom(32'h4782C290);
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(CTRL_ADDR, 8'h00);
    rd(8'($urandom) | 8'h01, RD_ZERO);
    wr(8'h08);
    rd(CTRL_ADDR, 8'h08);
    wr(8'h00);
    rd(CTRL_ADDR, 8'h08);
    // Protected clear on the last cycle of the window
    wr(8'h18);
    rd(CTRL_ADDR, 8'h18);
    repeat (2) op(1'b0, 1'b0, 8'h00, 8'h00);
    wr(8'h00);
    rd(CTRL_ADDR, 8'h00);
    // Clear one cycle after the window has closed
    wr(8'h08);
    wr(8'h18);
    repeat (4) op(1'b0, 1'b0, 8'h00, 8'h00);
    wr(8'h00);
    rd(CTRL_ADDR, 8'h08);
    wr(8'h0F);
    rd(CTRL_ADDR, 8'h08);
    for (int k = 0; k < 8; k++) begin
      v = 8'((k + 1) % 8);
      wr(8'h18);
      wr(8'h08 | v);
      rd(CTRL_ADDR, 8'h08 | v);
    end
    // Restart after 2000 ticks, then run to time-out with code 000
    op(1'b0, 1'b0, 8'h00, 8'h00);
    tick(2000);
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    tick_n = 0;
    tick(16400);
    chk("pulses", 8'(pulses), 8'h01);
    chk("delay", 8'(hit >= 16384 && hit <= 16387), 8'h01);
    // Safety level 2 after a second reset
    @(posedge clk);
    nrst <= 1'b0;
    fuse <= 1'b1;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(CTRL_ADDR, 8'h08);
    wr(8'h18);
    v = 8'($urandom_range(7));
    wr(v);
    rd(CTRL_ADDR, 8'h08 | v);
    // Clear attempt at level 2 with code 000: the watchdog still times out
    wr(8'h18);
    wr(8'h00);
    rd(CTRL_ADDR, 8'h08);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    pulses = 0;
    hit = 0;
    tick_n = 0;
    tick(16400);
    chk("pulses2", 8'(pulses), 8'h01);
    chk("delay2", 8'(hit >= 16384 && hit <= 16387), 8'h01);
    chk("queue", 8'(expq.size()), 8'h00);
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule
